/* core/mdm_regs.svh */
// Constants shared by the station end and the device end of the management link.
// Assumes it is included by bare name from files under core/.
`ifndef MDM_REGS_SVH
`define MDM_REGS_SVH

// ----------------------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------------------
`define MDM_PRE_BITS 6'd32
`define MDM_PRE_LAST 6'd31
`define MDM_OP_READ 2'b10
`define MDM_OP_WRITE 2'b01
`define MDM_TA_WRITE 2'b10
`define MDM_TA_READ 2'b11
`define MDM_START 2'b01
`define MDM_OP_LAST 4'h1
`define MDM_ADDR_LAST 4'h9
`define MDM_DATA_LAST 4'hf
`define MDM_FRAME_BITS 7'd32
`define MDM_FULL_BITS 7'd64
`define MDM_PRE_WORD 32'hffffffff
`define MDM_RD_RELEASE 7'd18
`define MDM_RD_TA2_LEFT 7'd16

// ----------------------------------------------------------------------------
// Device register space
// ----------------------------------------------------------------------------
`define MDM_REG_BMS 5'h01
`define MDM_REG_CFG1 5'h1b
`define MDM_BMS_VALUE 16'h0040
`define MDM_CFG1_PULL_BIT 5
`define MDM_REG_RESET 16'h0000

// ----------------------------------------------------------------------------
// Station clocking and command registers
// ----------------------------------------------------------------------------
`define MDM_REF_KHZ 200000
`define MDM_MDC_MAX_KHZ 25000
`define MDM_MDC_HALF ((`MDM_REF_KHZ + 2 * `MDM_MDC_MAX_KHZ - 1) / (2 * `MDM_MDC_MAX_KHZ))
`define MDM_OFS_CMD 8'h00
`define MDM_OFS_ADDR 8'h04
`define MDM_OFS_WDATA 8'h08
`define MDM_OFS_RDATA 8'h0c
`define MDM_OFS_STATUS 8'h10
`define MDM_CMD_GO_BIT 0
`define MDM_CMD_READ_BIT 1
`define MDM_CMD_PRE_BIT 2
`define MDM_RESP_OKAY 2'b00
`define MDM_RESP_DECERR 2'b11

`endif

/* core/mdm_pkg.sv */
// Types shared by both ends of the management link.
// Assumes mdm_regs.svh supplies the numeric constants.
package mdm_pkg;

  typedef enum logic [2:0] {
    MDM_D_PRE,
    MDM_D_IDLE,
    MDM_D_START,
    MDM_D_OPC,
    MDM_D_ADDR,
    MDM_D_TA,
    MDM_D_DATA
  } mdm_dev_e;

  typedef enum logic [1:0] {
    MDM_S_IDLE,
    MDM_S_SHIFT,
    MDM_S_GAP
  } mdm_sta_e;

endpackage : mdm_pkg

/* core/mdm_if.sv */
// Interface carrying the management clock and the shared data line.
// Assumes one station and one device attach; the line level is resolved here.
`timescale 1ns/1ps
`default_nettype none

interface mdm_if #(
  parameter bit EXT_PULL = 1'b1
);
  logic mdc;
  logic sta_o;
  logic sta_oe;
  logic dev_o;
  logic dev_oe;
  logic dev_pull_en;
  logic mdio;

  // With no driver the line floats to the pull-up; an unpulled line reads low.
  assign mdio = sta_oe ? sta_o : (dev_oe ? dev_o : (EXT_PULL | dev_pull_en));

  modport sta (output mdc, output sta_o, output sta_oe, input mdio);
  modport dev (input mdc, input mdio, output dev_o, output dev_oe, output dev_pull_en);
endinterface : mdm_if

`default_nettype wire

/* core/mdm_dev.sv */
// Device end of the serial management link: frame decoder and register space.
// Assumes the station makes the management clock and the bench joins the interface.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_regs.svh"

module mdm_dev (
  mdm_if.dev LINK, // Management clock and shared data line.
  input wire logic RST_N_I, // Asynchronous reset, active low.
  input wire logic [4:0] PHYAD_I, // Configured port address.
  output logic PULL_EN_O, // Internal pull-up enabled.
  output logic SYNCED_O // Preamble seen, frames accepted.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam logic [1:0] TA_WR = `MDM_TA_WRITE;
  mdm_pkg::mdm_dev_e state;
  logic [4:0] phyad_meta;
  logic [4:0] phyad;
  logic [5:0] pre_cnt;
  logic [3:0] bit_cnt;
  logic [1:0] op;
  logic [9:0] addr;
  logic [15:0] shreg;
  logic [15:0] regs [32];
  logic dev_o;
  logic dev_oe;
  logic hit;
  logic is_write;
  logic is_read;
  logic fail;
  logic [15:0] rd_value;

  // --------------------------------------------------------------------------
  // Port address synchroniser
  // --------------------------------------------------------------------------
  // The address pins may change at any time, so they pass two flops first.
  always_ff @(posedge LINK.mdc or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phyad_meta <= 5'h00;
      phyad <= 5'h00;
    end else begin
      phyad_meta <= PHYAD_I;
      phyad <= phyad_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------------
  assign hit = (addr[9:5] == phyad);
  assign is_write = (op == `MDM_OP_WRITE);
  assign is_read = (op == `MDM_OP_READ);

  always_comb begin
    fail = 1'b0;
    unique case (state)
      mdm_pkg::MDM_D_START: fail = !LINK.mdio;
      mdm_pkg::MDM_D_OPC: fail = (bit_cnt == `MDM_OP_LAST) &&
          ({op[0], LINK.mdio} != `MDM_OP_READ) && ({op[0], LINK.mdio} != `MDM_OP_WRITE);
      mdm_pkg::MDM_D_TA: fail = is_write &&
          (LINK.mdio != TA_WR[(bit_cnt == 4'h0) ? 1'b1 : 1'b0]);
      default: fail = 1'b0;
    endcase
  end

  always_comb begin
    if (addr[4:0] == `MDM_REG_BMS) begin
      rd_value = `MDM_BMS_VALUE;
    end else begin
      rd_value = regs[addr[4:0]];
    end
  end

  // --------------------------------------------------------------------------
  // Frame state machine
  // --------------------------------------------------------------------------
  // Every data-line bit is taken on the rising management clock edge.
  always_ff @(posedge LINK.mdc or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= mdm_pkg::MDM_D_PRE;
      pre_cnt <= 6'd0;
      bit_cnt <= 4'h0;
      op <= 2'b00;
      addr <= 10'h000;
      SYNCED_O <= 1'b0;
    end else if (fail) begin
      // A bad start, opcode or write turnaround drops sync until a fresh preamble.
      state <= mdm_pkg::MDM_D_PRE;
      pre_cnt <= 6'd0;
      SYNCED_O <= 1'b0;
    end else begin
      unique case (state)
        mdm_pkg::MDM_D_PRE: begin
          if (!LINK.mdio) begin
            pre_cnt <= 6'd0;
          end else if (pre_cnt == `MDM_PRE_LAST) begin
            state <= mdm_pkg::MDM_D_IDLE;
            SYNCED_O <= 1'b1;
          end else begin
            pre_cnt <= pre_cnt + 6'd1;
          end
        end
        mdm_pkg::MDM_D_IDLE: begin
          // Further ones are idle; no preamble is demanded again.
          if (!LINK.mdio) begin
            state <= mdm_pkg::MDM_D_START;
          end
        end
        mdm_pkg::MDM_D_START: begin
          state <= mdm_pkg::MDM_D_OPC;
          bit_cnt <= 4'h0;
        end
        mdm_pkg::MDM_D_OPC: begin
          op <= {op[0], LINK.mdio};
          if (bit_cnt == `MDM_OP_LAST) begin
            state <= mdm_pkg::MDM_D_ADDR;
            bit_cnt <= 4'h0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        mdm_pkg::MDM_D_ADDR: begin
          addr <= {addr[8:0], LINK.mdio};
          if (bit_cnt == `MDM_ADDR_LAST) begin
            state <= mdm_pkg::MDM_D_TA;
            bit_cnt <= 4'h0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        mdm_pkg::MDM_D_TA: begin
          if (bit_cnt == 4'h0) begin
            bit_cnt <= 4'h1;
          end else begin
            state <= mdm_pkg::MDM_D_DATA;
            bit_cnt <= 4'h0;
          end
        end
        mdm_pkg::MDM_D_DATA: begin
          if (bit_cnt == `MDM_DATA_LAST) begin
            state <= mdm_pkg::MDM_D_IDLE;
            bit_cnt <= 4'h0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Data line driver and shift register
  // --------------------------------------------------------------------------
  // Output changes just after the rising edge, so the station sees a full
  // bit period of stable data before its own sampling edge.
  always_ff @(posedge LINK.mdc or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dev_o <= 1'b0;
      dev_oe <= 1'b0;
      shreg <= 16'h0000;
    end else if (fail) begin
      dev_o <= 1'b0;
      dev_oe <= 1'b0;
    end else begin
      unique case (state)
        mdm_pkg::MDM_D_TA: begin
          if (bit_cnt == 4'h0) begin
            // First turnaround bit is left alone; drive zero for the second.
            if (is_read && hit) begin
              dev_oe <= 1'b1;
              dev_o <= 1'b0;
              shreg <= rd_value;
            end
          end else if (dev_oe) begin
            dev_o <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end
        end
        mdm_pkg::MDM_D_DATA: begin
          if (is_write) begin
            shreg <= {shreg[14:0], LINK.mdio};
          end else if (bit_cnt == `MDM_DATA_LAST) begin
            dev_oe <= 1'b0;
            dev_o <= 1'b0;
          end else if (dev_oe) begin
            dev_o <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end
        end
        default: begin
          dev_oe <= 1'b0;
          dev_o <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register space
  // --------------------------------------------------------------------------
  // The status register is hard wired, so a write to it is dropped.
  always_ff @(posedge LINK.mdc or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= `MDM_REG_RESET;
      end
    end else if ((state == mdm_pkg::MDM_D_DATA) && (bit_cnt == `MDM_DATA_LAST) &&
                 is_write && hit && (addr[4:0] != `MDM_REG_BMS)) begin
      regs[addr[4:0]] <= {shreg[14:0], LINK.mdio};
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign PULL_EN_O = regs[`MDM_REG_CFG1][`MDM_CFG1_PULL_BIT];
  assign LINK.dev_pull_en = regs[`MDM_REG_CFG1][`MDM_CFG1_PULL_BIT];
  assign LINK.dev_o = dev_o;
  assign LINK.dev_oe = dev_oe;

endmodule : mdm_dev

`default_nettype wire

/* core/mdm_sta.sv */
// Station end of the serial management link with an AXI4-Lite command port.
// Assumes software polls the status register; the device joins through mdm_if.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_regs.svh"

module mdm_sta (
  input wire logic REF_CLK_I, // System clock, 200 MHz.
  input wire logic RST_N_I, // Asynchronous reset, active low.
  input wire logic [7:0] AWADDR_I, // Write address.
  input wire logic AWVALID_I, // Write address valid.
  output logic AWREADY_O, // Write address ready.
  input wire logic [31:0] WDATA_I, // Write data.
  input wire logic [3:0] WSTRB_I, // Write byte strobes.
  input wire logic WVALID_I, // Write data valid.
  output logic WREADY_O, // Write data ready.
  output logic [1:0] BRESP_O, // Write response.
  output logic BVALID_O, // Write response valid.
  input wire logic BREADY_I, // Write response ready.
  input wire logic [7:0] ARADDR_I, // Read address.
  input wire logic ARVALID_I, // Read address valid.
  output logic ARREADY_O, // Read address ready.
  output logic [31:0] RDATA_O, // Read data.
  output logic [1:0] RRESP_O, // Read response.
  output logic RVALID_O, // Read data valid.
  input wire logic RREADY_I, // Read data ready.
  mdm_if.sta LINK // Management clock and shared data line.
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  localparam logic [2:0] PH_HALF = 3'(`MDM_MDC_HALF);
  localparam logic [2:0] PH_LAST = 3'(2 * `MDM_MDC_HALF - 1);
  mdm_pkg::mdm_sta_e state;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [2:0] cmd;
  logic [9:0] maddr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic busy;
  logic noans;
  logic go;
  logic [63:0] fr;
  logic [6:0] left;
  logic [2:0] ph;
  logic [15:0] rsh;
  logic mdc;
  logic mdo;
  logic mdoe;
  logic sync1;
  logic sync2;
  logic wr_now;

  assign wr_now = !AWREADY_O && !WREADY_O && !BVALID_O;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= `MDM_RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        AWREADY_O <= 1'b0;
        aw_addr <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        WREADY_O <= 1'b0;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end
      if (wr_now) begin
        BVALID_O <= 1'b1;
        unique case (aw_addr)
          `MDM_OFS_CMD, `MDM_OFS_ADDR, `MDM_OFS_WDATA: BRESP_O <= `MDM_RESP_OKAY;
          default: BRESP_O <= `MDM_RESP_DECERR;
        endcase
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  // Command registers; a start while busy is ignored.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd <= 3'h0;
      maddr <= 10'h000;
      wdata <= 16'h0000;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (wr_now && w_strb[0] && (aw_addr == `MDM_OFS_CMD)) begin
        // The running frame reads cmd, so it is frozen while busy.
        if (!busy) cmd <= w_data[2:0];
        go <= w_data[`MDM_CMD_GO_BIT] && !busy;
      end
      if (wr_now && (aw_addr == `MDM_OFS_ADDR)) begin
        if (w_strb[0]) maddr[9:5] <= w_data[4:0];
        if (w_strb[1]) maddr[4:0] <= w_data[12:8];
      end
      if (wr_now && (aw_addr == `MDM_OFS_WDATA)) begin
        if (w_strb[0]) wdata[7:0] <= w_data[7:0];
        if (w_strb[1]) wdata[15:8] <= w_data[15:8];
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `MDM_RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RRESP_O <= `MDM_RESP_OKAY;
      unique case (ARADDR_I)
        `MDM_OFS_CMD: RDATA_O <= {29'h0, cmd[2:1], 1'b0};
        `MDM_OFS_ADDR: RDATA_O <= {19'h0, maddr[4:0], 3'h0, maddr[9:5]};
        `MDM_OFS_WDATA: RDATA_O <= {16'h0, wdata};
        `MDM_OFS_RDATA: RDATA_O <= {16'h0, rdata};
        `MDM_OFS_STATUS: RDATA_O <= {30'h0, noans, busy};
        default: begin
          RDATA_O <= 32'h00000000;
          RRESP_O <= `MDM_RESP_DECERR;
        end
      endcase
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Data line synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= LINK.mdio;
      sync2 <= sync1;
    end
  end

  // --------------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------------
  // The clock is a divider of the system clock and rests low between frames.
  // Bits change as the clock falls and are read back as it rises.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= mdm_pkg::MDM_S_IDLE;
      busy <= 1'b0;
      noans <= 1'b0;
      rdata <= 16'h0000;
      fr <= 64'h0;
      left <= 7'd0;
      ph <= 3'h0;
      rsh <= 16'h0000;
      mdc <= 1'b0;
      mdo <= 1'b0;
      mdoe <= 1'b0;
    end else begin
      unique case (state)
        mdm_pkg::MDM_S_IDLE: begin
          mdc <= 1'b0;
          mdoe <= 1'b0;
          ph <= 3'h0;
          if (go) begin
            busy <= 1'b1;
            state <= mdm_pkg::MDM_S_SHIFT;
            if (cmd[`MDM_CMD_PRE_BIT]) begin
              // Thirty-two driven ones synchronise the device.
              fr <= {`MDM_PRE_WORD, `MDM_START, cmd[`MDM_CMD_READ_BIT] ? `MDM_OP_READ :
                  `MDM_OP_WRITE, maddr, cmd[`MDM_CMD_READ_BIT] ? `MDM_TA_READ :
                  `MDM_TA_WRITE, wdata};
              left <= `MDM_FULL_BITS;
            end else begin
              fr <= {`MDM_START, cmd[`MDM_CMD_READ_BIT] ? `MDM_OP_READ : `MDM_OP_WRITE,
                  maddr, cmd[`MDM_CMD_READ_BIT] ? `MDM_TA_READ : `MDM_TA_WRITE, wdata,
                  32'h0};
              left <= `MDM_FRAME_BITS;
            end
          end
        end
        mdm_pkg::MDM_S_SHIFT: begin
          ph <= (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
          if (ph == 3'h0) begin
            mdc <= 1'b0;
            mdo <= fr[63];
            fr <= {fr[62:0], 1'b0};
            mdoe <= !(cmd[`MDM_CMD_READ_BIT] && (left <= `MDM_RD_RELEASE));
            left <= left - 7'd1;
          end else if (ph == PH_HALF) begin
            mdc <= 1'b1;
            if (cmd[`MDM_CMD_READ_BIT] && (left == `MDM_RD_TA2_LEFT)) begin
              noans <= sync2;
            end else if (cmd[`MDM_CMD_READ_BIT] && (left < `MDM_RD_TA2_LEFT)) begin
              rsh <= {rsh[14:0], sync2};
            end
          end else if ((ph == PH_LAST) && (left == 7'd0)) begin
            state <= mdm_pkg::MDM_S_GAP;
          end
        end
        mdm_pkg::MDM_S_GAP: begin
          // One released idle bit lets the device free the line.
          ph <= (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
          if (ph == 3'h0) begin
            mdc <= 1'b0;
            mdoe <= 1'b0;
          end else if (ph == PH_HALF) begin
            mdc <= 1'b1;
          end else if (ph == PH_LAST) begin
            state <= mdm_pkg::MDM_S_IDLE;
            busy <= 1'b0;
            if (cmd[`MDM_CMD_READ_BIT]) rdata <= rsh;
          end
        end
        default: state <= mdm_pkg::MDM_S_IDLE;
      endcase
    end
  end

  assign LINK.mdc = mdc;
  assign LINK.sta_o = mdo;
  assign LINK.sta_oe = mdoe;

endmodule : mdm_sta

`default_nettype wire

/* tb/mdm_properties.sv */
// Checker for the management link between the station end and the device end.
// Assumes the bench hands it the signals of the interface that joins the two ends.
`timescale 1ns/1ps
`default_nettype none

module mdm_properties (
  input wire logic REF_CLK_I, // System clock.
  input wire logic RST_N_I, // Reset, active low.
  input wire logic mdc, // Link clock.
  input wire logic sta_o, // Station data.
  input wire logic sta_oe, // Station enable.
  input wire logic dev_o, // Device data.
  input wire logic dev_oe, // Device enable.
  input wire logic mdio // Resolved line.
);
  // --------------------------------------------------------------------------
  // Answer length
  // --------------------------------------------------------------------------
  // Counts link edges with the device driving, so a short or long answer shows.
  logic [4:0] held;
  always_ff @(posedge mdc or negedge RST_N_I) begin
    if (!RST_N_I) begin
      held <= 5'h00;
    end else begin
      held <= dev_oe ? held + 5'h01 : 5'h00;
    end
  end

  a_no_contention: assert property (
    @(posedge REF_CLK_I) disable iff (!RST_N_I) !(sta_oe && dev_oe))
    else $error("both ends drive the line");
  a_ta_released: assert property (
    @(posedge mdc) disable iff (!RST_N_I) $rose(dev_oe) |-> !sta_oe && !$past(sta_oe))
    else $error("first turnaround bit driven");
  a_answer_timing: assert property (
    @(posedge mdc) disable iff (!RST_N_I) $rose(dev_oe) |-> $past(sta_oe, 2))
    else $error("answer not two bits after header");
  a_ta_zero: assert property (
    @(posedge mdc) disable iff (!RST_N_I) $rose(dev_oe) |-> !mdio)
    else $error("second turnaround bit not zero");
  a_drive_len: assert property (
    @(posedge mdc) disable iff (!RST_N_I) $fell(dev_oe) |-> held == 5'd17)
    else $error("answer length wrong");
  a_dev_edge: assert property (
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    ($changed(dev_o) || $changed(dev_oe)) |-> $rose(mdc))
    else $error("device changed off the rising edge");
  a_sta_edge: assert property (
    @(posedge REF_CLK_I) disable iff (!RST_N_I)
    ($changed(sta_o) || $changed(sta_oe)) |-> !mdc)
    else $error("station changed while clock high");
  a_mdc_rate: assert property (
    @(posedge REF_CLK_I) disable iff (!RST_N_I) $rose(mdc) |-> mdc[*4] ##1 !mdc[*4])
    else $error("link clock too fast");
endmodule : mdm_properties

`default_nettype wire

/* tb/tb_mdio_management_slave.sv */
// Bench for the station and device ends; a second device is clocked bit by bit.
// Assumes a 200 MHz system clock and that the link resolves the line itself.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_regs.svh"

module tb_mdio_management_slave;
  logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, pull_en, synced, synced_b;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, st;
  logic [1:0] bresp, rresp, resp;
  logic [18:0] cap;
  logic [31:0] bad [4] = '{32'h20000000, 32'h40000000, 32'h70000000, 32'h538b1234};
  logic [63:0] hdr = {2'b01, `MDM_OP_READ, 5'h07, 5'h01, 50'h0};
  int fails, check_count;
  mdm_if lnk ();
  mdm_if lnk_b ();
  mdm_sta i_mdm_sta (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hf),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .LINK(lnk.sta));
  mdm_dev i_mdm_dev (.LINK(lnk.dev), .RST_N_I(rst_n), .PHYAD_I(5'h05), .PULL_EN_O(pull_en),
    .SYNCED_O(synced));
  mdm_dev i_mdm_dev_b (.LINK(lnk_b.dev), .RST_N_I(rst_n), .PHYAD_I(5'h07), .PULL_EN_O(),
    .SYNCED_O(synced_b));
  mdm_properties i_mdm_properties (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .mdc(lnk.mdc),
    .sta_o(lnk.sta_o), .sta_oe(lnk.sta_oe), .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe),
    .mdio(lnk.mdio));

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge ref_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // One link transfer through the station; status is kept, read result left in v.
  task automatic op(input logic [2:0] c, input logic [4:0] p, input logic [4:0] r,
      input logic [15:0] d);
    wr(`MDM_OFS_ADDR, {19'h0, r, 3'h0, p});
    wr(`MDM_OFS_WDATA, {16'h0, d});
    wr(`MDM_OFS_CMD, {29'h0, c});
    do rd(`MDM_OFS_STATUS); while (v[0]);
    st = v;
    rd(`MDM_OFS_RDATA);
  endtask : op

  // The second device's clock stands still between calls.
  task automatic bang(input logic [63:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      lnk_b.sta_oe = 1'b1;
      lnk_b.sta_o = b[63 - i];
      #7.5 lnk_b.mdc = 1'b1;
      #7.5 lnk_b.mdc = 1'b0;
    end
    lnk_b.sta_oe = 1'b0;
  endtask : bang

  // Released line: two turnaround bits, sixteen data bits, one idle bit.
  task automatic listen;
    for (int i = 0; i < 19; i++) begin
      #7.5 cap = {cap[17:0], lnk_b.mdio};
      lnk_b.mdc = 1'b1;
      #7.5 lnk_b.mdc = 1'b0;
    end
  endtask : listen

  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    #300000;
    fails++;
    wrap_up;
  end

  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {lnk_b.mdc, lnk_b.sta_o, lnk_b.sta_oe} = 3'b010;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    op(3'b011, 5'h05, 5'h01, 16'h0);
    chk(st[1], 1'b1);
    chk(synced, 1'b0);
    rd(`MDM_OFS_ADDR);
    chk(v, 32'h00000105);
    op(3'b101, 5'h05, 5'h05, 16'h1234);
    chk(synced, 1'b1);
    rd(`MDM_OFS_WDATA);
    chk(v, 32'h00001234);
    op(3'b011, 5'h05, 5'h05, 16'h0);
    chk(v, 32'h1234);
    op(3'b001, 5'h03, 5'h05, 16'hbeef);
    op(3'b011, 5'h03, 5'h05, 16'h0);
    chk(st[1], 1'b1);
    op(3'b011, 5'h05, 5'h05, 16'h0);
    chk(v, 32'h1234);
    done("address");
    op(3'b001, 5'h05, 5'h01, 16'hffff);
    for (int r = 0; r < 32; r++) op(3'b001, 5'h05, r[4:0], {3'h5, r[4:0], 3'h2, r[4:0]});
    for (int r = 0; r < 32; r++) begin
      op(3'b011, 5'h05, r[4:0], 16'h0);
      chk(v, r == 1 ? 32'h0040 : {16'h0, 3'h5, r[4:0], 3'h2, r[4:0]});
    end
    done("registers");
    op(3'b001, 5'h05, 5'h1b, 16'h0020);
    chk(pull_en, 1'b1);
    op(3'b001, 5'h05, 5'h1b, 16'h0);
    chk(pull_en, 1'b0);
    rd(8'h20);
    chk(resp, 2'b11);
    wr(8'h20, 32'h0);
    chk(resp, 2'b11);
    done("pull and bus");
    bang('1, 31);
    bang(hdr, 14);
    listen;
    chk(cap, 19'h7ffff);
    for (int i = 0; i < 4; i++) begin
      bang('1, 32);
      chk(synced_b, 1'b1);
      bang(hdr, 14);
      listen;
      chk(cap, 19'h40081);
      bang({bad[i], 32'h0}, 32);
      chk(synced_b, 1'b0);
    end
    bang(hdr, 14);
    listen;
    chk(cap, 19'h7ffff);
    done("line");
    wrap_up;
  end
endmodule : tb_mdio_management_slave

`default_nettype wire
